// ===== pkg/sfc_consts.svh
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH

// Opcodes
`define SFC_OP_ARM_WRITE 8'h06
`define SFC_OP_DISARM_WRITE 8'h04
`define SFC_OP_READ_JEDEC_ID 8'h9F
`define SFC_OP_READ_STATUS 8'h05
`define SFC_OP_WRITE_STATUS 8'h01
`define SFC_OP_READ 8'h03
`define SFC_OP_FAST_READ 8'h0B
`define SFC_OP_PARALLEL 8'h55
`define SFC_OP_BLOCK_WIPE_A 8'h20
`define SFC_OP_BLOCK_WIPE_B 8'hD8
`define SFC_OP_CHIP_WIPE_A 8'h60
`define SFC_OP_CHIP_WIPE_B 8'hC7
`define SFC_OP_PAGE_WRITE 8'h02
`define SFC_OP_DEEP_SLEEP 8'hB9
`define SFC_OP_ENTER_PARAM 8'hA5
`define SFC_OP_EXIT_PARAM 8'hB5
`define SFC_OP_WAKE 8'hAB
`define SFC_OP_READ_MAKER_PART 8'h90

// Status register layout
`define SFC_SR_BUSY 0
`define SFC_SR_WRITE_LATCH 1
`define SFC_SR_LEVEL_LO 2
`define SFC_SR_LEVEL_HI 4
`define SFC_SR_ZERO 5
`define SFC_SR_ERROR 6
`define SFC_SR_LOCK 7
`define SFC_LEVEL_NONE 3'h0
`define SFC_LEVEL_ALL 3'h7
`define SFC_LEVEL_STEP 3'h1

// Array map: 64 sectors of 64 Kbyte on 22-bit addresses
`define SFC_SECT_LSB 16
`define SFC_SECT_MSB 21
`define SFC_SECTORS 7'h40
`define SFC_ONE_SECTOR 7'h01

// Framing counts
`define SFC_BIT_FIRST 3'h0
`define SFC_BIT_LAST 3'h7
`define SFC_BIT_STEP 3'h1
`define SFC_CNT_FIRST 3'h0
`define SFC_CNT_STEP 3'h1
`define SFC_ADDR_LAST 3'h2
`define SFC_FAST_DUMMY_LAST 3'h0
`define SFC_SIG_DUMMY_LAST 3'h2
`define SFC_ID_MAKER 3'h0
`define SFC_ID_TYPE 3'h1
`define SFC_BYTE_ZERO 8'h00
`define SFC_BYTE_ERASED 8'hFF
`define SFC_STATUS_RESET 8'h00

// Busy timer lengths in clk_in cycles
`define SFC_STATUS_CYC 24'h000400
`define SFC_PROG_CYC 24'h001000
`define SFC_SECT_CYC 24'h004000
`define SFC_CHIP_CYC 24'h010000
`define SFC_CYC_ONE 24'h000001

`endif

// ===== pkg/sfc_pkg.sv
package sfc_pkg;

   typedef enum logic [2:0] {
      LNK_OP,
      LNK_ADDR,
      LNK_DUMMY,
      LNK_DATA,
      LNK_OUT,
      LNK_DONE,
      LNK_IGNORE
   } sfc_link_e;

   typedef enum logic [1:0] {
      JOB_STATUS,
      JOB_PROG,
      JOB_SECT,
      JOB_CHIP
   } sfc_job_e;

   typedef struct packed {
      sfc_job_e job;
      logic [21:0] addr;
      logic [5:0] sector;
      logic [7:0] data;
      logic param_sector;
   } sfc_job_s;

   typedef struct packed {
      logic sleep;
      logic [7:0] status;
   } sfc_mirror_s;

   typedef struct packed {
      logic cs_n;
      logic frame_tog;
      logic protect_n;
   } sfc_pins_s;

endpackage : sfc_pkg

// ===== core/sfc_sync.sv
module sfc_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);

   logic [W-1:0] meta_q;

   // The first stage is read by the second stage only
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         meta_q <= '0;
         q_out <= '0;
      end else begin
         meta_q <= d_in;
         q_out <= meta_q;
      end
   end

endmodule : sfc_sync

// ===== core/sfc_timer.sv
`include "sfc_consts.svh"

module sfc_timer (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic start_in,
   input wire logic [23:0] len_in,
   output logic busy_out,
   output logic done_out
);

   logic [23:0] cnt_q;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt_q <= 24'h000000;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in && !busy_out) begin
            cnt_q <= len_in;
            busy_out <= 1'b1;
         end else if (busy_out) begin
            if (cnt_q <= `SFC_CYC_ONE) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end else begin
               cnt_q <= cnt_q - `SFC_CYC_ONE;
            end
         end
      end
   end

endmodule : sfc_timer

// ===== core/sfc_command_port.sv
// Contract
// - Pause halts link, internal jobs keep running
// - Pause starts on pause low, clock low; the output here floats as soon as pause goes low, at any clock level
// - Pause ends on pause high, clock low
// - Paused: output floats, input and clock ignored
// - Select high resets link; resume needs both
// - Arm, disarm latch; JEDEC id three bytes
// - Status read shifts out; status write takes byte
// - Read, fast read, parallel mode framing
// - Sector, chip erase and page program framing
// - Deep sleep, parameter sector enter and exit
// - Wake, signature read, maker part id read
// - Order byte picks which id goes first
// - 64 sectors of 64 Kbyte, 22-bit address
// - Unknown opcode: standby until next frame
// - Known opcode: active until select rises
// - Sample rising, shift falling, modes 0, 3
// - Reads may end after any output bit
// - Write-type commands need exact byte boundary
// - Busy: array access ignored, job undisturbed
// - Status bit layout, bit 5 reads zero
// - Latch clears at reset and job completion
// - Protect level guards topmost sectors, doubling
// - Chip erase only with protect level zero
`include "sfc_consts.svh"

module sfc_command_port
   import sfc_pkg::*;
#(
   parameter logic [23:0] STATUS_CYC = `SFC_STATUS_CYC,
   parameter logic [23:0] PROG_CYC = `SFC_PROG_CYC,
   parameter logic [23:0] SECT_CYC = `SFC_SECT_CYC,
   parameter logic [23:0] CHIP_CYC = `SFC_CHIP_CYC,
   // Identity values are arbitrary
   parameter logic [7:0] MAKER_ID = 8'h5A,
   parameter logic [7:0] MEM_TYPE = 8'h11,
   parameter logic [7:0] PART_ID = 8'h22,
   parameter logic [7:0] SIGNATURE = 8'h33
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   input wire logic hold_n_in,
   input wire logic protect_boost_pin_n_in,
   output logic so_out,
   output logic so_oe_n_out,
   output logic [7:0] status_out,
   output logic deep_sleep_out,
   output logic param_sector_out,
   output logic parallel_mode_out,
   output logic job_valid_out,
   output sfc_job_s job_out
);

   // Link side, clocked by sck_in
   sfc_link_e st_q;
   sfc_link_e st_d;
   logic [2:0] bit_q;
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic [7:0] sr_q;
   logic [7:0] nxt_byte;
   logic ok_q;
   logic ok_d;
   logic tog_q;
   logic [7:0] op_q;
   logic [23:0] addr_q;
   logic [7:0] wdata_q;
   logic [7:0] out_byte;
   logic frame_rst;
   logic so_rst;
   sfc_mirror_s mirror_q;
   sfc_mirror_s mirror_s;
   logic lnk_busy;

   // Core side, clocked by clk_in
   sfc_pins_s pins_raw;
   sfc_pins_s pins_s;
   logic cs_prev_q;
   logic seen_q;
   logic exec;
   logic write_latch_q;
   logic [2:0] protect_level_q;
   logic status_lock_q;
   logic error_q;
   logic sleep_q;
   logic param_q;
   logic par_q;
   logic busy_flag;
   logic job_done;
   logic [5:0] sector;
   logic prot_hit;
   logic is_page;
   logic is_wipe;
   logic is_chip;
   logic start_st;
   logic start_pp;
   logic start_se;
   logic start_ce;
   logic start_any;
   logic rej_prot;
   logic [23:0] job_len;

   assign nxt_byte = {sr_q[6:0], si_in};
   // Raising select clears framing even in the middle of a pause
   assign frame_rst = reset_in | cs_n_in;
   assign so_rst = frame_rst | ~hold_n_in;
   assign lnk_busy = mirror_s.status[`SFC_SR_BUSY];

   // Status crosses as a slow-changing word; a skew of one sck edge
   // between bits is harmless because each bit only changes rarely.
   sfc_sync #(
      .W($bits(sfc_mirror_s))
   ) u_mirror_sync (
      .clk_in(sck_in),
      .reset_in(reset_in),
      .d_in(mirror_q),
      .q_out(mirror_s)
   );

   // Opcode and framing decode, evaluated on the last bit of each byte
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      ok_d = 1'b0;
      if (bit_q == `SFC_BIT_LAST) begin
         cnt_d = cnt_q + `SFC_CNT_STEP;
         case (st_q)
            LNK_OP: begin
               cnt_d = `SFC_CNT_FIRST;
               st_d = LNK_IGNORE;
               if (mirror_s.sleep) begin
                  if (nxt_byte == `SFC_OP_WAKE) begin
                     st_d = LNK_DUMMY;
                     ok_d = 1'b1;
                  end
               end else if (lnk_busy) begin
                  // Only status polling is decoded while a job runs
                  if (nxt_byte == `SFC_OP_READ_STATUS) begin
                     st_d = LNK_OUT;
                  end
               end else begin
                  case (nxt_byte)
                     `SFC_OP_ARM_WRITE, `SFC_OP_DISARM_WRITE, `SFC_OP_PARALLEL,
                     `SFC_OP_CHIP_WIPE_A, `SFC_OP_CHIP_WIPE_B, `SFC_OP_DEEP_SLEEP,
                     `SFC_OP_ENTER_PARAM, `SFC_OP_EXIT_PARAM: begin
                        st_d = LNK_DONE;
                        ok_d = 1'b1;
                     end
                     `SFC_OP_WAKE: begin
                        st_d = LNK_DUMMY;
                        ok_d = 1'b1;
                     end
                     `SFC_OP_READ_STATUS, `SFC_OP_READ_JEDEC_ID: begin
                        st_d = LNK_OUT;
                     end
                     `SFC_OP_WRITE_STATUS: begin
                        st_d = LNK_DATA;
                     end
                     `SFC_OP_READ, `SFC_OP_FAST_READ, `SFC_OP_BLOCK_WIPE_A,
                     `SFC_OP_BLOCK_WIPE_B, `SFC_OP_PAGE_WRITE,
                     `SFC_OP_READ_MAKER_PART: begin
                        st_d = LNK_ADDR;
                     end
                     default: begin
                        st_d = LNK_IGNORE;
                     end
                  endcase
               end
            end
            LNK_ADDR: begin
               if (cnt_q == `SFC_ADDR_LAST) begin
                  cnt_d = `SFC_CNT_FIRST;
                  case (op_q)
                     `SFC_OP_READ, `SFC_OP_READ_MAKER_PART: begin
                        st_d = LNK_OUT;
                     end
                     `SFC_OP_FAST_READ: begin
                        st_d = LNK_DUMMY;
                     end
                     `SFC_OP_PAGE_WRITE: begin
                        st_d = LNK_DATA;
                        ok_d = 1'b1;
                     end
                     default: begin
                        st_d = LNK_DONE;
                        ok_d = 1'b1;
                     end
                  endcase
               end
            end
            LNK_DUMMY: begin
               if ((op_q == `SFC_OP_FAST_READ && cnt_q == `SFC_FAST_DUMMY_LAST) ||
                   (op_q == `SFC_OP_WAKE && cnt_q == `SFC_SIG_DUMMY_LAST)) begin
                  cnt_d = `SFC_CNT_FIRST;
                  st_d = LNK_OUT;
               end
            end
            LNK_DATA: begin
               // Page data keeps the frame valid on every whole byte
               ok_d = 1'b1;
               if (op_q == `SFC_OP_WRITE_STATUS) begin
                  st_d = LNK_DONE;
               end
            end
            LNK_OUT: begin
               st_d = LNK_OUT;
            end
            default: begin
               st_d = st_q;
            end
         endcase
      end
   end

   // Framing state: cleared by select high, frozen while paused
   always_ff @(posedge sck_in or posedge frame_rst) begin
      if (frame_rst) begin
         st_q <= LNK_OP;
         bit_q <= `SFC_BIT_FIRST;
         cnt_q <= `SFC_CNT_FIRST;
         sr_q <= `SFC_BYTE_ZERO;
      end else if (hold_n_in) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         bit_q <= bit_q + `SFC_BIT_STEP;
         sr_q <= nxt_byte;
      end
   end

   // Captured frame; survives select high so the core can read it
   always_ff @(posedge sck_in or posedge reset_in) begin
      if (reset_in) begin
         ok_q <= 1'b0;
         tog_q <= 1'b0;
         op_q <= `SFC_BYTE_ZERO;
         addr_q <= 24'h000000;
         wdata_q <= `SFC_BYTE_ZERO;
      end else if (!cs_n_in && hold_n_in) begin
         ok_q <= ok_d;
         if (st_q == LNK_OP && bit_q == `SFC_BIT_FIRST) begin
            tog_q <= ~tog_q;
         end
         if (st_q == LNK_OP && bit_q == `SFC_BIT_LAST) begin
            op_q <= nxt_byte;
         end
         if (st_q == LNK_ADDR && bit_q == `SFC_BIT_LAST) begin
            addr_q <= {addr_q[15:0], nxt_byte};
         end
         if (st_q == LNK_DATA && bit_q == `SFC_BIT_LAST) begin
            wdata_q <= nxt_byte;
         end
      end
   end

   // Byte offered on the serial output
   always_comb begin
      out_byte = `SFC_BYTE_ZERO;
      case (op_q)
         `SFC_OP_READ_STATUS: begin
            out_byte = mirror_s.status;
         end
         `SFC_OP_READ_JEDEC_ID: begin
            if (cnt_q == `SFC_ID_MAKER) begin
               out_byte = MAKER_ID;
            end else if (cnt_q == `SFC_ID_TYPE) begin
               out_byte = MEM_TYPE;
            end else begin
               out_byte = PART_ID;
            end
         end
         `SFC_OP_READ_MAKER_PART: begin
            out_byte = (cnt_q[0] ^ addr_q[0]) ? PART_ID : MAKER_ID;
         end
         `SFC_OP_WAKE: begin
            out_byte = SIGNATURE;
         end
         `SFC_OP_READ, `SFC_OP_FAST_READ: begin
            // No array behind this port; reads stream erased bytes
            out_byte = `SFC_BYTE_ERASED;
         end
         default: begin
            out_byte = `SFC_BYTE_ZERO;
         end
      endcase
   end

   // Output changes on falling edges. A pause floats the pin at once;
   // it comes back at the first falling edge after the pause ends.
   always_ff @(negedge sck_in or posedge so_rst) begin
      if (so_rst) begin
         so_out <= 1'b0;
         so_oe_n_out <= 1'b1;
      end else begin
         so_out <= out_byte[~bit_q];
         so_oe_n_out <= (st_q != LNK_OUT);
      end
   end

   // Core side
   assign pins_raw = '{cs_n: cs_n_in, frame_tog: tog_q, protect_n: protect_boost_pin_n_in};

   sfc_sync #(
      .W($bits(sfc_pins_s))
   ) u_pin_sync (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .d_in(pins_raw),
      .q_out(pins_s)
   );

   // A frame counts only if it saw clocks and ended on a good boundary
   assign exec = pins_s.cs_n & ~cs_prev_q & (pins_s.frame_tog != seen_q) & ok_q;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cs_prev_q <= 1'b1;
         seen_q <= 1'b0;
      end else begin
         cs_prev_q <= pins_s.cs_n;
         if (pins_s.cs_n && !cs_prev_q) begin
            seen_q <= pins_s.frame_tog;
         end
      end
   end

   assign sector = addr_q[`SFC_SECT_MSB:`SFC_SECT_LSB];
   assign prot_hit = (protect_level_q == `SFC_LEVEL_ALL) ||
      ((protect_level_q != `SFC_LEVEL_NONE) &&
       ({1'b0, sector} >= (`SFC_SECTORS -
        (`SFC_ONE_SECTOR << (protect_level_q - `SFC_LEVEL_STEP)))));
   assign is_page = (op_q == `SFC_OP_PAGE_WRITE);
   assign is_wipe = (op_q == `SFC_OP_BLOCK_WIPE_A) || (op_q == `SFC_OP_BLOCK_WIPE_B);
   assign is_chip = (op_q == `SFC_OP_CHIP_WIPE_A) || (op_q == `SFC_OP_CHIP_WIPE_B);
   assign start_st = exec & write_latch_q & (op_q == `SFC_OP_WRITE_STATUS) &
      ~(status_lock_q & ~pins_s.protect_n);
   assign start_pp = exec & write_latch_q & is_page & ~prot_hit;
   assign start_se = exec & write_latch_q & is_wipe & ~prot_hit;
   assign start_ce = exec & write_latch_q & is_chip &
      (protect_level_q == `SFC_LEVEL_NONE);
   assign start_any = start_st | start_pp | start_se | start_ce;
   assign rej_prot = exec & write_latch_q & (((is_page | is_wipe) & prot_hit) |
      (is_chip & (protect_level_q != `SFC_LEVEL_NONE)));

   always_comb begin
      job_len = STATUS_CYC;
      if (start_pp) begin
         job_len = PROG_CYC;
      end else if (start_se) begin
         job_len = SECT_CYC;
      end else if (start_ce) begin
         job_len = CHIP_CYC;
      end
   end

   // Jobs run on clk_in, so a pause on the link never stalls them
   sfc_timer u_job_timer (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .start_in(start_any),
      .len_in(job_len),
      .busy_out(busy_flag),
      .done_out(job_done)
   );

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         write_latch_q <= 1'b0;
      end else if (exec && op_q == `SFC_OP_ARM_WRITE) begin
         write_latch_q <= 1'b1;
      end else if (job_done || (exec && op_q == `SFC_OP_DISARM_WRITE)) begin
         write_latch_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         protect_level_q <= `SFC_LEVEL_NONE;
         status_lock_q <= 1'b0;
      end else if (start_st) begin
         protect_level_q <= wdata_q[`SFC_SR_LEVEL_HI:`SFC_SR_LEVEL_LO];
         status_lock_q <= wdata_q[`SFC_SR_LOCK];
      end
   end

   // A new program or erase job clears the error flag; a status write leaves it; a fresh refusal wins over it
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         error_q <= 1'b0;
      end else if (rej_prot) begin
         error_q <= 1'b1;
      end else if (start_pp || start_se || start_ce) begin
         error_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sleep_q <= 1'b0;
         param_q <= 1'b0;
         par_q <= 1'b0;
      end else if (exec) begin
         if (op_q == `SFC_OP_DEEP_SLEEP) begin
            sleep_q <= 1'b1;
         end else if (op_q == `SFC_OP_WAKE) begin
            sleep_q <= 1'b0;
         end
         if (op_q == `SFC_OP_ENTER_PARAM) begin
            param_q <= 1'b1;
         end else if (op_q == `SFC_OP_EXIT_PARAM) begin
            param_q <= 1'b0;
         end
         if (op_q == `SFC_OP_PARALLEL) begin
            par_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         mirror_q <= '{sleep: 1'b0, status: `SFC_STATUS_RESET};
      end else begin
         mirror_q.sleep <= sleep_q;
         mirror_q.status <= {status_lock_q, error_q, 1'b0, protect_level_q,
            write_latch_q, busy_flag};
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         status_out <= `SFC_STATUS_RESET;
         deep_sleep_out <= 1'b0;
         param_sector_out <= 1'b0;
         parallel_mode_out <= 1'b0;
      end else begin
         status_out <= mirror_q.status;
         deep_sleep_out <= sleep_q;
         param_sector_out <= param_q;
         parallel_mode_out <= par_q;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         job_valid_out <= 1'b0;
         job_out <= '0;
      end else begin
         job_valid_out <= start_any;
         if (start_any) begin
            job_out.job <= start_st ? JOB_STATUS : start_pp ? JOB_PROG :
               start_se ? JOB_SECT : JOB_CHIP;
            job_out.addr <= addr_q[21:0];
            job_out.sector <= sector;
            job_out.data <= wdata_q;
            job_out.param_sector <= param_q;
         end
      end
   end

endmodule : sfc_command_port

// ===== sim/sfc_command_port_asserts.sv
module sfc_command_port_asserts
   import sfc_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic hold_n_in,
   input wire logic so_oe_n_out,
   input wire logic [7:0] status_out,
   input wire logic deep_sleep_out,
   input wire logic parallel_mode_out,
   input wire logic job_valid_out,
   input wire sfc_job_s job_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   zero_bit_a: assert property (status_out[5] == 1'b0)
      else $error("status bit 5 set");
   job_pulse_a: assert property (job_valid_out |=> !job_valid_out)
      else $error("job pulse too long");
   job_busy_a: assert property (job_valid_out |-> ##[0:4] status_out[0])
      else $error("busy not raised");
   job_armed_a: assert property (job_valid_out |-> status_out[1])
      else $error("job without latch");
   latch_clear_a: assert property ($fell(status_out[0]) |-> ##[0:2] !status_out[1])
      else $error("latch kept after job");
   chip_level_a: assert property (job_valid_out && job_out.job == JOB_CHIP
      |-> status_out[4:2] == 3'h0)
      else $error("chip erase while protected");
   sector_map_a: assert property (job_valid_out && job_out.job inside {JOB_PROG, JOB_SECT}
      |-> job_out.sector == job_out.addr[21:16])
      else $error("sector field wrong");
   awake_job_a: assert property (job_valid_out |-> !deep_sleep_out)
      else $error("job while asleep");
   parallel_hold_a: assert property (parallel_mode_out |=> parallel_mode_out)
      else $error("parallel mode dropped");
   float_cs_a: assert property (cs_n_in [*2] |-> so_oe_n_out)
      else $error("output driven while deselected");
   float_hold_a: assert property (!hold_n_in && !sck_in |=> so_oe_n_out || hold_n_in)
      else $error("output driven while paused");
endmodule : sfc_command_port_asserts

bind sfc_command_port sfc_command_port_asserts sfc_command_port_asserts_i (.*);

// ===== sim/sfc_host.sv
module sfc_host (
   output logic sck_out,
   output logic cs_n_out,
   output logic si_out,
   output logic hold_n_out,
   input wire logic so_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic mode3 = 1'b0;
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
      hold_n_out = 1'b1;
   end
   // Odd setup delay keeps link edges off the core clock edges
   task automatic xfer(input logic [47:0] tx, input int n, input int pz, output logic [47:0] rx);
      rx = '0;
      sck_out = mode3;
      #21.2 cs_n_out = 1'b0;
      for (int i = 0; i < n; i++) begin
         sck_out = 1'b0;
         if (i == pz) begin
            hold_n_out = 1'b0;
            si_out = ~si_out;
            #7.5 sck_out = 1'b1;
            #7.5 sck_out = 1'b0;
            si_out = ~si_out;
            #7.5 sck_out = 1'b1;
            // Released while high, so the pause ends at the next fall
            #3.5 hold_n_out = 1'b1;
            #4 sck_out = 1'b0;
         end
         si_out = tx[47 - i];
         #7.5 sck_out = 1'b1;
         rx = {rx[46:0], so_in};
         #7.5;
      end
      sck_out = mode3;
      si_out = ~si_out;
      #20 cs_n_out = 1'b1;
      #150;
   endtask : xfer
endmodule : sfc_host

// ===== sim/serial_flash_command_port_tb.sv
module serial_flash_command_port_tb
   import sfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Identity values are arbitrary
   localparam logic [7:0] MK = 8'hA1;
   localparam logic [7:0] TY = 8'hB2;
   localparam logic [7:0] PT = 8'hC3;
   localparam logic [7:0] SG = 8'hD4;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic prot_n = 1'b1;
   logic drove = 1'b0;
   logic sck, cs_n, si, hold_n, so, so_oe_n, deep, param, par, jv;
   logic [7:0] st;
   logic [47:0] rx;
   logic [7:0] ops[4] = '{8'h60, 8'hC7, 8'h20, 8'hD8};
   sfc_job_s job, last;
   int miscompares = 0;
   int check_count = 0;
   int cyc = 0;
   int jobs = 0;
   // A released line shows the inverse, so a float never reads as data
   wire so_w = so_oe_n ? ~so : so;

   sfc_command_port #(.STATUS_CYC(24'h000004), .PROG_CYC(24'h000004), .SECT_CYC(24'h0000C8),
      .CHIP_CYC(24'h000004), .MAKER_ID(MK), .MEM_TYPE(TY), .PART_ID(PT), .SIGNATURE(SG))
   sfc_command_port_i (.clk_in(clk_in), .reset_in(reset_in), .sck_in(sck), .cs_n_in(cs_n),
      .si_in(si), .hold_n_in(hold_n), .protect_boost_pin_n_in(prot_n), .so_out(so),
      .so_oe_n_out(so_oe_n), .status_out(st), .deep_sleep_out(deep),
      .param_sector_out(param), .parallel_mode_out(par), .job_valid_out(jv), .job_out(job));
   sfc_host sfc_host_i (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n),
      .so_in(so_w));

   initial forever #5 clk_in = ~clk_in;
   initial begin
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b0;
   end
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (jv) begin
         jobs <= jobs + 1;
         last <= job;
      end
      if (!so_oe_n) drove <= 1'b1;
      if (cyc == 30000) begin
         miscompares++;
         wrap_up;
      end
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cmd(input logic [47:0] tx, input int n, input int pz = -1);
      sfc_host_i.xfer(tx, n, pz, rx);
   endtask : cmd
   task automatic arm;
      cmd({8'h06, 40'h0}, 8);
   endtask : arm
   task automatic wrap_up;
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   task automatic t_reset;
      chk({st, so_oe_n, deep, param, par, jv}, 13'h0010);
   endtask : t_reset
   task automatic t_ids;
      cmd({8'h9F, 40'h0}, 32);
      chk(rx[23:0], {MK, TY, PT});
      sfc_host_i.mode3 = 1'b1;
      cmd({8'h9F, 40'h0}, 32);
      chk(rx[23:0], {MK, TY, PT});
      sfc_host_i.mode3 = 1'b0;
      cmd({8'h9F, 40'h0}, 32, 4);
      chk(rx[23:0], {MK, TY, PT});
      cmd({8'h9F, 40'h0}, 32, 20);
      chk(rx[23:0], {MK, TY, PT});
      cmd({8'h90, 40'h0}, 48);
      chk(rx[15:0], {MK, PT});
      cmd({8'h90, 16'h0, 8'h01, 16'h0}, 48);
      chk(rx[15:0], {PT, MK});
      cmd({8'hAB, 40'h0}, 40);
      chk(rx[7:0], SG);
      cmd({8'h0B, 40'h0}, 48);
      chk(rx[7:0], 8'hFF);
      cmd({8'h03, 40'h0}, 44);
      chk(rx[11:0], 12'hFFF);
      cmd({8'h05, 40'h0}, 24);
      chk(rx[15:0], 16'h0000);
   endtask : t_ids
   task automatic t_latch;
      arm;
      chk(st[1], 1'b1);
      cmd({8'h04, 40'h0}, 9);
      chk(st[1], 1'b1);
      cmd({8'h04, 40'h0}, 8);
      chk(st[1], 1'b0);
   endtask : t_latch
   task automatic t_jobs;
      int j;
      arm;
      cmd({8'h01, 8'h04, 32'h0}, 16);
      chk({last.job, last.data, st}, {JOB_STATUS, 8'h04, 8'h04});
      arm;
      j = jobs;
      cmd({8'h02, 24'h3F0010, 8'h5A, 8'h0}, 40);
      chk({jobs, st[6]}, {j, 1'b1});
      arm;
      cmd({8'h02, 24'h3E0010, 8'h5A, 8'h0}, 40);
      chk({last.job, last.addr, last.sector, last.data, st[6]},
         {JOB_PROG, 22'h3E0010, 6'h3E, 8'h5A, 1'b0});
      arm;
      j = jobs;
      cmd({8'h60, 40'h0}, 8);
      chk(jobs, j);
      arm;
      cmd({8'h01, 8'h00, 32'h0}, 16);
      foreach (ops[i]) begin
         arm;
         cmd({ops[i], 24'h3FFFFF, 16'h0}, i < 2 ? 8 : 32);
         chk(last.job, i < 2 ? JOB_CHIP : JOB_SECT);
         if (i >= 2) begin
            chk(last.sector, 6'h3F);
            arm;
            cmd({8'h05, 40'h0}, 16);
            chk(rx[7:0], 8'h03);
            #2500;
            chk(st, 8'h00);
         end
      end
      // Lock plus a low protect pin must refuse the status write
      arm;
      cmd({8'h01, 8'h80, 32'h0}, 16);
      prot_n <= 1'b0;
      arm;
      cmd({8'h01, 8'h04, 32'h0}, 16);
      chk(st, 8'h82);
   endtask : t_jobs
   task automatic t_modes;
      cmd({8'hB9, 40'h0}, 8);
      chk(deep, 1'b1);
      drove = 1'b0;
      cmd({8'h9F, 40'h0}, 32);
      chk(drove, 1'b0);
      cmd({8'hAB, 40'h0}, 8);
      chk(deep, 1'b0);
      drove = 1'b0;
      cmd({8'hFF, 40'h0}, 16);
      chk(drove, 1'b0);
      cmd({8'hA5, 40'h0}, 8);
      chk(param, 1'b1);
      arm;
      cmd({8'h02, 24'h000100, 8'h11, 8'h0}, 40);
      chk({last.job, last.param_sector}, {JOB_PROG, 1'b1});
      cmd({8'hB5, 40'h0}, 8);
      chk(param, 1'b0);
      cmd({8'h55, 40'h0}, 8);
      chk(par, 1'b1);
   endtask : t_modes

   initial begin
      repeat (6) @(posedge clk_in);
      t_reset;
      t_ids;
      t_latch;
      t_jobs;
      t_modes;
      wrap_up;
   end
endmodule : serial_flash_command_port_tb
